/* File: fplc_regs.vh */
// fplc_regs.vh: constants for the pad cell, wide decoder and logic cell
// assumes inclusion by each design file; definitions only
`ifndef FPLC_REGS_VH
`define FPLC_REGS_VH

// pad output source select
`define FPLC_OSEL_DIRECT 2'h0
`define FPLC_OSEL_INVERT 2'h1
`define FPLC_OSEL_REG 2'h2
// pad input path select
`define FPLC_ISEL_RAW 2'h0
`define FPLC_ISEL_MASTER 2'h1
`define FPLC_ISEL_SLAVE 2'h2
// decoders per edge
`define FPLC_DEC_FULL 4
`define FPLC_DEC_REDUCED 2
// decoder width: pad inputs plus local lines
`define FPLC_DEC_PADS 8
`define FPLC_DEC_LOCAL 8
`define FPLC_DEC_W 16
// logic cell control input roles (fourth input is combining input)
`define FPLC_CTL_CE 0
`define FPLC_CTL_SR 1
`define FPLC_CTL_DIN 2
`define FPLC_CTL_H 3
// flip-flop source select in logic cell
`define FPLC_FSEL_F 2'h0
`define FPLC_FSEL_G 2'h1
`define FPLC_FSEL_H 2'h2
`define FPLC_FSEL_DIN 2'h3

`endif

/* File: fplc_pad_cell.v */
// fplc_pad_cell.v: one pad cell, output and input paths with two flip-flops each
// assumes static configuration inputs and global set/reset gsr

`include "fplc_regs.vh"

module fplc_pad_cell (
  input wire clk,
  input wire gsr,
  input wire [1:0] cfg_out_sel,
  input wire cfg_oe_inv,
  input wire cfg_out_init,
  input wire cfg_in_init,
  input wire cfg_out_neg,
  input wire cfg_in_neg,
  input wire [1:0] cfg_path_a_sel,
  input wire [1:0] cfg_path_b_sel,
  input wire out_data,
  input wire out_tri,
  input wire pad_i,
  output reg pad_o,
  output wire pad_oe,
  output reg pad_input_path_a,
  output reg pad_input_path_b
);

  reg out_pos_ff;
  reg out_neg_ff;
  reg in_slave_ff;
  reg in_neg_ff;
  wire out_reg_q;
  wire in_slave_q;
  wire in_master_q;

  // both edges built, polarity select picks one
  always @(posedge clk or posedge gsr) begin
    if (gsr) begin
      out_pos_ff <= 1'b0;
      in_slave_ff <= 1'b0;
    end else begin
      out_pos_ff <= out_data ^ cfg_out_init;
      in_slave_ff <= pad_i ^ cfg_in_init;
    end
  end

  always @(negedge clk or posedge gsr) begin
    if (gsr) begin
      out_neg_ff <= 1'b0;
      in_neg_ff <= 1'b0;
    end else begin
      out_neg_ff <= out_data ^ cfg_out_init;
      in_neg_ff <= pad_i ^ cfg_in_init;
    end
  end

  // stored value xor init: gsr drives stored bit to zero, output to init
  assign out_reg_q = (cfg_out_neg ? out_neg_ff : out_pos_ff) ^ cfg_out_init;
  assign in_slave_q = (cfg_in_neg ? in_neg_ff : in_slave_ff) ^ cfg_in_init;
  // master latch: transparent in phase opposite the capture edge, else holds capture
  assign in_master_q = gsr ? cfg_in_init :
                       ((cfg_in_neg ? clk : ~clk) ? pad_i : in_slave_q);

  always @* begin
    case (cfg_out_sel)
      `FPLC_OSEL_INVERT: pad_o = ~out_data;
      `FPLC_OSEL_REG: pad_o = out_reg_q;
      default: pad_o = out_data;
    endcase
  end

  assign pad_oe = out_tri ^ cfg_oe_inv;

  always @* begin
    case (cfg_path_a_sel)
      `FPLC_ISEL_MASTER: pad_input_path_a = in_master_q;
      `FPLC_ISEL_SLAVE: pad_input_path_a = in_slave_q;
      default: pad_input_path_a = pad_i;
    endcase
    case (cfg_path_b_sel)
      `FPLC_ISEL_MASTER: pad_input_path_b = in_master_q;
      `FPLC_ISEL_SLAVE: pad_input_path_b = in_slave_q;
      default: pad_input_path_b = pad_i;
    endcase
  end

endmodule

/* File: fplc_wide_dec.v */
// fplc_wide_dec.v: one wide AND decoder with per-input select and invert
// assumes static configuration; inputs are pad paths then local lines

`include "fplc_regs.vh"

module fplc_wide_dec (
  input wire [`FPLC_DEC_W-1:0] dec_in,
  input wire [`FPLC_DEC_W-1:0] cfg_use,
  input wire [`FPLC_DEC_W-1:0] cfg_inv,
  input wire cfg_split,
  output wire dec_out_lo,
  output wire dec_out_hi
);

  localparam HALF = `FPLC_DEC_W / 2;
  // unused inputs read as true
  wire [`FPLC_DEC_W-1:0] term = (dec_in ^ cfg_inv) | ~cfg_use;
  wire and_lo = &term[HALF-1:0];
  wire and_hi = &term[`FPLC_DEC_W-1:HALF];

  assign dec_out_lo = cfg_split ? and_lo : (and_lo & and_hi);
  assign dec_out_hi = cfg_split ? and_hi : (and_lo & and_hi);

endmodule

/* File: fplc_fabric.v */
// fplc_fabric.v: one edge of pad cells with wide decoders, plus a logic cell
// assumes configuration ports are held static while gsr is released

`include "fplc_regs.vh"

module fplc_fabric #(
  parameter REDUCED = 0
) (
  input wire clk,
  input wire gsr,
  input wire [2*`FPLC_DEC_PADS-1:0] cfg_pad_out_sel,
  input wire [`FPLC_DEC_PADS-1:0] cfg_pad_oe_inv,
  input wire [`FPLC_DEC_PADS-1:0] cfg_pad_out_init,
  input wire [`FPLC_DEC_PADS-1:0] cfg_pad_in_init,
  input wire [`FPLC_DEC_PADS-1:0] cfg_pad_out_neg,
  input wire [`FPLC_DEC_PADS-1:0] cfg_pad_in_neg,
  input wire [2*`FPLC_DEC_PADS-1:0] cfg_pad_path_a_sel,
  input wire [2*`FPLC_DEC_PADS-1:0] cfg_pad_path_b_sel,
  input wire [`FPLC_DEC_PADS-1:0] pad_out_data,
  input wire [`FPLC_DEC_PADS-1:0] pad_out_tri,
  input wire [`FPLC_DEC_PADS-1:0] pad_i,
  output wire [`FPLC_DEC_PADS-1:0] pad_o,
  output wire [`FPLC_DEC_PADS-1:0] pad_oe,
  output wire [`FPLC_DEC_PADS-1:0] pad_input_path_a,
  output wire [`FPLC_DEC_PADS-1:0] pad_input_path_b,
  input wire [`FPLC_DEC_LOCAL-1:0] dec_local,
  input wire [`FPLC_DEC_FULL*`FPLC_DEC_W-1:0] cfg_dec_use,
  input wire [`FPLC_DEC_FULL*`FPLC_DEC_W-1:0] cfg_dec_inv,
  input wire [`FPLC_DEC_FULL-1:0] cfg_dec_split,
  output wire [2*`FPLC_DEC_FULL-1:0] dec_out,
  input wire [15:0] cfg_lut_f,
  input wire [15:0] cfg_lut_g,
  input wire [7:0] cfg_lut_h,
  input wire cfg_mem_en,
  input wire cfg_sr_is_set,
  input wire [1:0] cfg_ffx_sel,
  input wire [1:0] cfg_ffy_sel,
  input wire [3:0] cell_f_in,
  input wire [3:0] cell_g_in,
  input wire cell_control_input_first,
  input wire cell_control_input_second,
  input wire cell_control_input_third,
  input wire cell_control_input_fourth,
  input wire [1:0] cell_dec_sel,
  output wire cell_f_out,
  output wire cell_g_out,
  output wire cell_h_out,
  output wire cell_x_q,
  output wire cell_y_q
);

  localparam NDEC = REDUCED ? `FPLC_DEC_REDUCED : `FPLC_DEC_FULL;

  wire [3:0] ctl;
  wire [`FPLC_DEC_W-1:0] dec_in;
  wire cell_ce;
  wire cell_sr;
  wire combining_stage_extra_input;
  wire cell_din;
  wire mem_we;
  wire memory_write_bit_low;
  wire memory_write_bit_high;
  wire dec_to_cell;
  wire [2:0] h_idx;
  reg [15:0] lut_f_ff;
  reg [15:0] lut_g_ff;
  reg mem_loaded_ff;
  reg ffx_ff;
  reg ffy_ff;
  reg nxt_ffx;
  reg nxt_ffy;

  genvar gi;
  generate
    for (gi = 0; gi < `FPLC_DEC_PADS; gi = gi + 1) begin : g_pad
      fplc_pad_cell u_pad (
        .clk(clk),
        .gsr(gsr),
        .cfg_out_sel(cfg_pad_out_sel[2*gi+1:2*gi]),
        .cfg_oe_inv(cfg_pad_oe_inv[gi]),
        .cfg_out_init(cfg_pad_out_init[gi]),
        .cfg_in_init(cfg_pad_in_init[gi]),
        .cfg_out_neg(cfg_pad_out_neg[gi]),
        .cfg_in_neg(cfg_pad_in_neg[gi]),
        .cfg_path_a_sel(cfg_pad_path_a_sel[2*gi+1:2*gi]),
        .cfg_path_b_sel(cfg_pad_path_b_sel[2*gi+1:2*gi]),
        .out_data(pad_out_data[gi]),
        .out_tri(pad_out_tri[gi]),
        .pad_i(pad_i[gi]),
        .pad_o(pad_o[gi]),
        .pad_oe(pad_oe[gi]),
        .pad_input_path_a(pad_input_path_a[gi]),
        .pad_input_path_b(pad_input_path_b[gi])
      );
    end
  endgenerate

  assign dec_in = {dec_local, pad_input_path_a};

  generate
    for (gi = 0; gi < `FPLC_DEC_FULL; gi = gi + 1) begin : g_dec
      if (gi < NDEC) begin : g_on
        fplc_wide_dec u_dec (
          .dec_in(dec_in),
          .cfg_use(cfg_dec_use[`FPLC_DEC_W*gi+`FPLC_DEC_W-1:`FPLC_DEC_W*gi]),
          .cfg_inv(cfg_dec_inv[`FPLC_DEC_W*gi+`FPLC_DEC_W-1:`FPLC_DEC_W*gi]),
          .cfg_split(cfg_dec_split[gi]),
          .dec_out_lo(dec_out[2*gi]),
          .dec_out_hi(dec_out[2*gi+1])
        );
      end else begin : g_off
        assign dec_out[2*gi+1:2*gi] = 2'h0;
      end
    end
  endgenerate

  // decoder output into the cell as combining input option
  assign dec_to_cell = dec_out[cell_dec_sel];

  // control input personalities
  assign ctl = {cell_control_input_fourth, cell_control_input_third,
                cell_control_input_second, cell_control_input_first};
  assign cell_ce = ctl[`FPLC_CTL_CE];
  assign cell_sr = ~cfg_mem_en & ctl[`FPLC_CTL_SR];
  assign cell_din = cfg_mem_en ? 1'b0 : ctl[`FPLC_CTL_DIN];
  assign combining_stage_extra_input = cfg_mem_en ? dec_to_cell :
                                       (ctl[`FPLC_CTL_H] | dec_to_cell);
  assign mem_we = cfg_mem_en & ctl[`FPLC_CTL_SR];
  assign memory_write_bit_low = ctl[`FPLC_CTL_DIN];
  assign memory_write_bit_high = ctl[`FPLC_CTL_H];

  // table contents loaded from configuration while gsr is held
  always @(posedge clk or posedge gsr) begin
    if (gsr) begin
      mem_loaded_ff <= 1'b0;
    end else begin
      mem_loaded_ff <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!mem_loaded_ff) begin
      lut_f_ff <= cfg_lut_f;
      lut_g_ff <= cfg_lut_g;
    end else if (mem_we) begin
      lut_f_ff[cell_f_in] <= memory_write_bit_low;
      lut_g_ff[cell_g_in] <= memory_write_bit_high;
    end
  end

  // memory disabled: tables follow configuration directly
  assign cell_f_out = cfg_mem_en ? lut_f_ff[cell_f_in] : cfg_lut_f[cell_f_in];
  assign cell_g_out = cfg_mem_en ? lut_g_ff[cell_g_in] : cfg_lut_g[cell_g_in];
  assign h_idx = {combining_stage_extra_input, cell_g_out, cell_f_out};
  assign cell_h_out = cfg_lut_h[h_idx];

  always @* begin
    case (cfg_ffx_sel)
      `FPLC_FSEL_G: nxt_ffx = cell_g_out;
      `FPLC_FSEL_H: nxt_ffx = cell_h_out;
      `FPLC_FSEL_DIN: nxt_ffx = cell_din;
      default: nxt_ffx = cell_f_out;
    endcase
    case (cfg_ffy_sel)
      `FPLC_FSEL_F: nxt_ffy = cell_f_out;
      `FPLC_FSEL_H: nxt_ffy = cell_h_out;
      `FPLC_FSEL_DIN: nxt_ffy = combining_stage_extra_input;
      default: nxt_ffy = cell_g_out;
    endcase
  end

  // stored bit xor polarity: async clear stands for set or reset
  always @(posedge clk or posedge gsr or posedge cell_sr) begin
    if (gsr | cell_sr) begin
      ffx_ff <= 1'b0;
      ffy_ff <= 1'b0;
    end else if (cell_ce) begin
      ffx_ff <= nxt_ffx ^ cfg_sr_is_set;
      ffy_ff <= nxt_ffy ^ cfg_sr_is_set;
    end
  end

  assign cell_x_q = ffx_ff ^ cfg_sr_is_set;
  assign cell_y_q = ffy_ff ^ cfg_sr_is_set;

endmodule

/* File: fplc_fabric_props.sv */
// fplc_fabric_props.sv: port assertions for the fabric top
// assumes bind into fplc_fabric; configuration held static between changes
module fplc_fabric_props (
  input wire clk,
  input wire gsr,
  input wire [15:0] cfg_pad_out_sel,
  input wire [7:0] cfg_pad_oe_inv,
  input wire [7:0] cfg_pad_out_init,
  input wire [15:0] cfg_pad_path_a_sel,
  input wire [7:0] pad_out_data,
  input wire [7:0] pad_out_tri,
  input wire [7:0] pad_i,
  input wire [7:0] pad_o,
  input wire [7:0] pad_oe,
  input wire [7:0] pad_input_path_a,
  input wire [7:0] dec_local,
  input wire [63:0] cfg_dec_use,
  input wire [63:0] cfg_dec_inv,
  input wire [3:0] cfg_dec_split,
  input wire [7:0] dec_out,
  input wire [15:0] cfg_lut_f,
  input wire cfg_mem_en,
  input wire cfg_sr_is_set,
  input wire [1:0] cfg_ffx_sel,
  input wire [3:0] cell_f_in,
  input wire cell_control_input_first,
  input wire cell_control_input_second,
  input wire cell_control_input_third,
  input wire cell_f_out,
  input wire cell_x_q,
  input wire cell_y_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  oe_polarity_a: assert property (disable iff (gsr)
    pad_oe == (pad_out_tri ^ cfg_pad_oe_inv)) else $error("pad enable polarity wrong");
  out_direct_a: assert property (disable iff (gsr)
    cfg_pad_out_sel[1:0] == 2'h0 |-> pad_o[0] == pad_out_data[0]) else $error("direct out");
  out_invert_a: assert property (disable iff (gsr)
    cfg_pad_out_sel[1:0] == 2'h1 |-> pad_o[0] != pad_out_data[0]) else $error("inverted out");
  pad_init_a: assert property (gsr && cfg_pad_out_sel[1:0] == 2'h2
    |-> pad_o[0] == cfg_pad_out_init[0]) else $error("pad flop init");
  cell_init_a: assert property (gsr |-> ##0 cell_x_q == cfg_sr_is_set
    && cell_y_q == cfg_sr_is_set) else $error("cell flop init");
  ce_hold_a: assert property (disable iff (gsr)
    !cell_control_input_first && !cell_control_input_second ##1 !cell_control_input_second
    |-> $stable(cell_x_q) && $stable(cell_y_q)) else $error("hold without enable");
  din_capture_a: assert property (disable iff (gsr)
    !gsr && cell_control_input_first && !cfg_mem_en && !cell_control_input_second
    && cfg_ffx_sel == 2'h3 ##1 !cell_control_input_second
    |-> cell_x_q == $past(cell_control_input_third)) else $error("direct data");
  dec_and_a: assert property (disable iff (gsr) !cfg_dec_split[0] |-> dec_out[0] ==
    &(({dec_local, pad_input_path_a} ^ cfg_dec_inv[15:0]) | ~cfg_dec_use[15:0]))
    else $error("decoder and");
  lut_f_a: assert property (disable iff (gsr)
    !cfg_mem_en |-> cell_f_out == cfg_lut_f[cell_f_in]) else $error("table f");
  path_raw_a: assert property (disable iff (gsr)
    cfg_pad_path_a_sel[1:0] == 2'h0 |-> pad_input_path_a[0] == pad_i[0]) else $error("raw");
endmodule

bind fplc_fabric fplc_fabric_props props (.*);

/* File: fplc_pin_model.sv */
// fplc_pin_model.sv: board side of the pads, pull-up on every pin
// assumes the device wins if both sides drive
module fplc_pin_model (
  input wire [7:0] pad_o,
  input wire [7:0] pad_oe,
  input wire [7:0] ext_drv,
  input wire [7:0] ext_en,
  output wire [7:0] pad_i
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_drv) | (~pad_oe & ~ext_en);
endmodule

/* File: fplc_fabric_test.sv */
// fplc_fabric_test.sv: directed tests of the fabric top
// assumes the pin model on the pads
module fplc_fabric_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, gsr = 1'h0, cfg_mem_en = 1'h0, cfg_sr_is_set = 1'h1;
  logic [15:0] cfg_pad_out_sel = 16'haaaa, cfg_pad_path_a_sel = 16'h0, cfg_lut_f = 16'h8000;
  logic [15:0] cfg_pad_path_b_sel = 16'haaaa, cfg_lut_g = 16'h0001;
  logic [7:0] cfg_pad_oe_inv = 8'hff, cfg_pad_out_init = 8'h5a, cfg_pad_in_init = 8'ha5;
  logic [7:0] cfg_pad_out_neg = 8'h0, cfg_pad_in_neg = 8'h0, pad_out_data = 8'h0;
  logic [7:0] pad_out_tri = 8'h0, dec_local = 8'h0, cfg_lut_h = 8'h80;
  logic [7:0] ext_drv = 8'h0, ext_en = 8'h0;
  logic [63:0] cfg_dec_use = {64{1'h1}}, cfg_dec_inv = 64'h0;
  logic [3:0] cfg_dec_split = 4'h0, cell_f_in = 4'h0, cell_g_in = 4'h0;
  logic [1:0] cfg_ffx_sel = 2'h3, cfg_ffy_sel = 2'h3, cell_dec_sel = 2'h0;
  logic cell_control_input_first = 1'h0, cell_control_input_second = 1'h0;
  logic cell_control_input_third = 1'h0, cell_control_input_fourth = 1'h0;
  wire [7:0] pad_i, pad_o, pad_oe, pad_input_path_a, pad_input_path_b, dec_out;
  wire cell_f_out, cell_g_out, cell_h_out, cell_x_q, cell_y_q;
  int n_fail = 0, checks = 0;
  fplc_fabric dut (.*);
  fplc_pin_model pins (.*);
  always #4 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic nx;
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    gsr <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    chk({pad_o, pad_input_path_b}, 16'h5aa5);
    chk({cell_x_q, cell_y_q}, 2'h3);
    @(posedge clk);
    gsr <= 1'h0;
    pad_out_data <= 8'h3c;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cfg_pad_out_sel <= {8{k[1:0]}};
      nx;
      chk(pad_o, k == 1 ? 8'hc3 : 8'h3c);
    end
    chk({pad_input_path_a, pad_input_path_b}, 16'h3c3c);
    @(posedge clk);
    pad_out_data <= 8'h81;
    cfg_pad_out_neg <= 8'hff;
    #1;
    chk(pad_o, 8'h3c);
    @(negedge clk);
    #1;
    chk(pad_o, 8'h81);
    @(posedge clk);
    cfg_pad_oe_inv <= 8'h0f;
    pad_out_tri <= 8'h33;
    ext_en <= 8'hff;
    ext_drv <= 8'h96;
    nx;
    chk({pad_oe, pad_input_path_a}, 16'h3c82);
    @(posedge clk);
    dec_local <= 8'h0f;
    cfg_dec_inv <= {4{16'hf07d}};
    nx;
    chk(dec_out, 8'hff);
    @(posedge clk);
    dec_local <= 8'h0e;
    cfg_dec_split <= 4'h2;
    nx;
    chk(dec_out, 8'h04);
    @(posedge clk);
    cfg_dec_inv <= 64'h0;
    cfg_dec_split <= 4'h0;
    cell_f_in <= 4'hf;
    cell_control_input_fourth <= 1'h1;
    nx;
    chk({cell_f_out, cell_g_out, cell_h_out}, 3'h7);
    @(posedge clk);
    cell_g_in <= 4'h1;
    nx;
    chk({cell_f_out, cell_g_out, cell_h_out}, 3'h4);
    @(posedge clk);
    cell_control_input_first <= 1'h1;
    nx;
    chk({cell_x_q, cell_y_q}, 2'h1);
    @(posedge clk);
    cell_control_input_first <= 1'h0;
    cell_control_input_third <= 1'h1;
    cell_control_input_fourth <= 1'h0;
    nx;
    chk({cell_x_q, cell_y_q}, 2'h1);
    @(posedge clk);
    cell_control_input_second <= 1'h1;
    #1;
    chk({cell_x_q, cell_y_q}, 2'h3);
    @(posedge clk);
    cell_control_input_second <= 1'h0;
    cell_control_input_first <= 1'h1;
    cell_control_input_third <= 1'h0;
    nx;
    chk({cell_x_q, cell_y_q}, 2'h0);
    @(posedge clk);
    gsr <= 1'h1;
    nx;
    chk({cell_x_q, cell_y_q, pad_o}, 10'h35a);
    @(posedge clk);
    gsr <= 1'h0;
    cell_f_in <= 4'h0;
    cell_control_input_third <= 1'h1;
    cell_control_input_fourth <= 1'h1;
    cfg_mem_en <= 1'h1;
    repeat (2) @(posedge clk);
    cell_control_input_second <= 1'h1;
    nx;
    chk({cell_f_out, cell_g_out}, 2'h3);
    @(posedge clk);
    ext_drv <= 8'h69;
    cfg_pad_path_a_sel <= 16'haaaa;
    cfg_pad_path_b_sel <= 16'h5555;
    cell_control_input_second <= 1'h0;
    cfg_ffx_sel <= 2'h2;
    cfg_ffy_sel <= 2'h0;
    cfg_lut_h <= 8'h08;
    #1;
    chk({pad_input_path_b, pad_input_path_a}, 16'h8282);
    @(negedge clk);
    #1;
    chk({pad_input_path_b, pad_input_path_a}, 16'h4182);
    nx;
    chk({cell_x_q, cell_y_q}, 2'h3);
    tally_and_finish;
  end
endmodule
